// [tcr_clock_reset.v]
// tcr_clock_reset.v: clock checker, lock and reset sequencing
// assumes ref_clk is the stable reconfiguration clock at 40 MHz,
// quad_pll_clk is the quad pll clock after a divide by 125, and clock
// pads are outside.
`include "tcr_defs.vh"

module tcr_clock_reset (
  input wire ref_clk,
  input wire reset_n,
  input wire shared_in_core,
  input wire rate_20g,
  input wire refclk_single,
  input wire refclk_pos,
  input wire refclk_neg,
  input wire quad_pll_clk,
  output reg core_system_clock,
  output reg pll_freq_locked,
  output reg refclk_fwd,
  output reg cfg_done,
  output reg core_reset_n
);
  // configuration states, one-hot
  localparam ST_RESET = 4'b0001;
  localparam ST_MEASURE = 4'b0010;
  localparam ST_LOCKED = 4'b0100;
  localparam ST_LOST = 4'b1000;

  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n_int;
  wire shared_s;
  wire rate_s;
  wire pll_s;
  wire diff_s;
  wire single_s;
  reg pll_prev_q;
  reg [`TCR_WIN_W-1:0] win_q;
  reg [23:0] edge_q;
  reg [3:0] good_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg win_ok;
  wire [23:0] exp_cnt;
  wire win_end;
  wire ref_sel;
  wire [`TCR_SYNC_N-1:0] sync_in;
  wire [`TCR_SYNC_N-1:0] sync_out;
  wire pll_rise;
  wire win_lo_ok;
  wire win_hi_ok;
  wire good_full;
  reg [3:0] good_d;

  // reset release through two flip-flops
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n_int = rst_sync_q;

  // pin and foreign clock inputs gathered for the synchroniser bank
  assign sync_in[`TCR_SYNC_SHARED] = shared_in_core;
  assign sync_in[`TCR_SYNC_RATE] = rate_20g;
  assign sync_in[`TCR_SYNC_PLL] = quad_pll_clk;
  assign sync_in[`TCR_SYNC_DIFF] = refclk_pos & ~refclk_neg;
  assign sync_in[`TCR_SYNC_SINGLE] = refclk_single;

  // one two flip-flop synchroniser per input, all on ref_clk
  genvar gi;
  generate
    for (gi = 0; gi < `TCR_SYNC_N; gi = gi + 1)
    begin : g_sync
      tcr_sync2 tcr_sync2_i (
        .clk(ref_clk),
        .rst_n(rst_n_int),
        .din(sync_in[gi]),
        .dout(sync_out[gi])
      );
    end
  endgenerate

  // synchronised copies by name
  assign shared_s = sync_out[`TCR_SYNC_SHARED];
  assign rate_s = sync_out[`TCR_SYNC_RATE];
  assign pll_s = sync_out[`TCR_SYNC_PLL];
  assign diff_s = sync_out[`TCR_SYNC_DIFF];
  assign single_s = sync_out[`TCR_SYNC_SINGLE];

  // reference source choice by shared logic placement
  assign ref_sel = shared_s ? diff_s : single_s;
  assign exp_cnt = rate_s ? `TCR_EXP_20G : `TCR_EXP_10G;
  assign win_end = (win_q == `TCR_WIN_ZERO);

  // lower and upper bounds of the edge count check
  assign win_lo_ok = (edge_q + `TCR_TOL >= exp_cnt);
  assign win_hi_ok = (edge_q <= exp_cnt + `TCR_TOL);

  // window check on the edge count
  always @*
  begin
    win_ok = win_lo_ok && win_hi_ok;
  end

  // rising edge of the sampled pll clock
  assign pll_rise = pll_s && !pll_prev_q;

  // edge counting over a ref_clk window
  always @(posedge ref_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      pll_prev_q <= 1'b0;
      win_q <= `TCR_WIN_CYC;
      edge_q <= `TCR_CNT_ZERO;
    end
    else
    begin
      pll_prev_q <= pll_s;
      if (win_end)
      begin
        win_q <= `TCR_WIN_CYC;
        edge_q <= `TCR_CNT_ZERO;
      end
      else
      begin
        win_q <= win_q - `TCR_WIN_ONE;
        if (pll_rise)
          edge_q <= edge_q + `TCR_CNT_ONE;
      end
    end
  end

  // configuration state machine on the stable clock
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RESET:
      begin
        state_d = ST_MEASURE;
      end
      ST_MEASURE:
      begin
        if (win_end && win_ok && good_full)
          state_d = ST_LOCKED;
      end
      ST_LOCKED:
      begin
        if (win_end && !win_ok)
          state_d = ST_LOST;
      end
      ST_LOST:
      begin
        state_d = ST_MEASURE;
      end
      default:
      begin
        state_d = ST_RESET;
      end
    endcase
  end

  // enough good windows in a row seen
  assign good_full = (good_q == `TCR_GOOD_NEED);

  // good-window count, cleared outside measuring or on a bad window
  always @*
  begin
    good_d = good_q;
    if (state_q != ST_MEASURE)
      good_d = `TCR_GOOD_ZERO;
    else if (win_end && !win_ok)
      good_d = `TCR_GOOD_ZERO;
    else if (win_end && !good_full)
      good_d = good_q + `TCR_GOOD_ONE;
  end

  // state and good-window counter
  always @(posedge ref_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      state_q <= ST_RESET;
      good_q <= `TCR_GOOD_ZERO;
    end
    else
    begin
      state_q <= state_d;
      good_q <= good_d;
    end
  end

  // registered outputs
  always @(posedge ref_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      core_system_clock <= 1'b0;
      pll_freq_locked <= 1'b0;
      refclk_fwd <= 1'b0;
      cfg_done <= 1'b0;
      core_reset_n <= 1'b0;
    end
    else
    begin
      core_system_clock <= pll_s;
      pll_freq_locked <= (state_d == ST_LOCKED);
      refclk_fwd <= shared_s & ref_sel;
      cfg_done <= (state_q == ST_LOCKED);
      core_reset_n <= (state_q == ST_LOCKED);
    end
  end
endmodule // tcr_clock_reset

// [tcr_clock_reset_monitor.sv]
// tcr_clock_reset_monitor.sv: port assertions for tcr_clock_reset
// assumes ref_clk at 40 MHz, bound onto the block
module tcr_monitor (
  input wire ref_clk,
  input wire reset_n,
  input wire shared_in_core,
  input wire refclk_pos,
  input wire refclk_neg,
  input wire quad_pll_clk,
  input wire core_system_clock,
  input wire pll_freq_locked,
  input wire refclk_fwd,
  input wire cfg_done,
  input wire core_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [14:0] cnt_q;
  // cycles since reset, saturating at four windows
  always @(posedge ref_clk or negedge reset_n)
    if (!reset_n) cnt_q <= 15'h0000;
    else if (cnt_q != 15'h3E80) cnt_q <= cnt_q + 15'h0001;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n || cnt_q < 15'h0008);
  lock_late_a: assert property (pll_freq_locked |-> cnt_q == 15'h3E80)
    else $error("lock before four windows");
  core_rel_a: assert property (
    $rose(core_reset_n) |-> pll_freq_locked)
    else $error("core reset released without lock");
  core_hold_a: assert property (!pll_freq_locked |=> !core_reset_n)
    else $error("core reset released while unlocked");
  cfg_lock_a: assert property ($rose(cfg_done) |-> pll_freq_locked)
    else $error("config done without lock");
  fwd_off_a: assert property ((!shared_in_core)[*4] |-> !refclk_fwd)
    else $error("forward active without shared logic");
  fwd_hi_a: assert property (
    (shared_in_core && refclk_pos && !refclk_neg)[*4] |-> refclk_fwd)
    else $error("forward not high");
  fwd_lo_a: assert property (
    (shared_in_core && !refclk_pos)[*4] |-> !refclk_fwd)
    else $error("forward not low");
  sys_hi_a: assert property (quad_pll_clk[*4] |-> core_system_clock)
    else $error("system clock not high");
  sys_lo_a: assert property (
    (!quad_pll_clk)[*4] |-> !core_system_clock)
    else $error("system clock not low");
endmodule // tcr_monitor
bind tcr_clock_reset tcr_monitor tcr_monitor_i (.ref_clk(ref_clk),
  .reset_n(reset_n), .shared_in_core(shared_in_core),
  .refclk_pos(refclk_pos), .refclk_neg(refclk_neg),
  .quad_pll_clk(quad_pll_clk), .core_system_clock(core_system_clock),
  .pll_freq_locked(pll_freq_locked), .refclk_fwd(refclk_fwd),
  .cfg_done(cfg_done), .core_reset_n(core_reset_n));

// [tcr_defs.vh]
// tcr_defs.vh: constants for the transceiver clock and reset block
// assumes inclusion by bare name from the design files
`ifndef TCR_DEFS_VH
`define TCR_DEFS_VH
// system clock frequencies in kHz for the two line rates
`define TCR_SYS_KHZ_10G 32'd156250
`define TCR_SYS_KHZ_20G 32'd312500
// reconfiguration clock rate in kHz (ref_clk, 40 MHz)
`define TCR_REF_KHZ 32'd40000
// measurement window in ref_clk cycles (4000 cycles, 100 us)
`define TCR_WIN_CYC 16'h0FA0
// window width, zero and step
`define TCR_WIN_W 16
`define TCR_WIN_ZERO 16'h0000
`define TCR_WIN_ONE 16'h0001
// expected tap edges per window: the pll clock arrives through a divide
// by 125, so 1.25 MHz (10G) or 2.5 MHz (20G) over 100 us
`define TCR_EXP_10G 24'h00_007D
`define TCR_EXP_20G 24'h00_00FA
// tolerance on the edge count per window
`define TCR_TOL 24'h00_0010
`define TCR_CNT_ZERO 24'h00_0000
`define TCR_CNT_ONE 24'h00_0001
// lock needs this many good windows in a row, then one more good window (four in all)
`define TCR_GOOD_NEED 4'h3
`define TCR_GOOD_ZERO 4'h0
`define TCR_GOOD_ONE 4'h1
// synchroniser bank size and bit positions
`define TCR_SYNC_N 5
`define TCR_SYNC_SHARED 0
`define TCR_SYNC_RATE 1
`define TCR_SYNC_PLL 2
`define TCR_SYNC_DIFF 3
`define TCR_SYNC_SINGLE 4
`endif

// [tcr_pll_model.sv]
// tcr_pll_model.sv: quad pll clock source model
// assumes ref_clk falling edge as its stepping point
module tcr_pll_model (
  input wire logic ref_clk,
  input wire logic [7:0] half,
  output logic pll_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] n;
  initial pll_clk = 1'b0;
  initial n = 8'h00;
  // toggle every half cycles, stand still low when half is zero
  always @(negedge ref_clk)
    if (half == 8'h00) pll_clk <= 1'b0;
    else if (n + 8'h01 >= half)
    begin
      n <= 8'h00;
      pll_clk <= ~pll_clk;
    end
    else n <= n + 8'h01;
endmodule // tcr_pll_model

// [tcr_sync2.v]
// tcr_sync2.v: two flip-flop level synchroniser
// assumes a level input from another domain and an active-low async reset
module tcr_sync2 (
  input wire clk,
  input wire rst_n,
  input wire din,
  output reg dout
);
  reg meta_q;

  // first stage feeds only the second stage
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // tcr_sync2

// [transceiver_clock_reset_tb.sv]
// transceiver_clock_reset_tb.sv: self-checking bench for tcr_clock_reset
// assumes the pll model and the bound monitor are compiled first
module transceiver_clock_reset_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset_n, shared, rate_20g, ref_se, ref_p, ref_n, pll;
  logic sys_clk, locked, fwd, cfg, core_rst_n, seen;
  logic [7:0] half;
  int err_total, checks, i, n;
`define CHK(s, e, v) begin checks++; if ((v) !== (e)) begin err_total++; \
  $display("wrong value %s exp %b got %b", s, e, v); end end
  // reconfiguration clock, not derived from the pll model
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  tcr_pll_model tcr_pll_model_i (.ref_clk(ref_clk), .half(half),
    .pll_clk(pll));
  tcr_clock_reset tcr_clock_reset_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .shared_in_core(shared), .rate_20g(rate_20g), .refclk_single(ref_se),
    .refclk_pos(ref_p), .refclk_neg(ref_n), .quad_pll_clk(pll),
    .core_system_clock(sys_clk), .pll_freq_locked(locked),
    .refclk_fwd(fwd), .cfg_done(cfg), .core_reset_n(core_rst_n));
  task t_fwd;
    shared = 1'b0;
    ref_p = 1'b1;
    ref_n = 1'b0;
    ref_se = 1'b1;
    repeat (5) @(negedge ref_clk);
    `CHK("fwd off", 1'b0, fwd)
    shared = 1'b1;
    repeat (5) @(negedge ref_clk);
    `CHK("fwd hi", 1'b1, fwd)
    ref_p = 1'b0;
    ref_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    `CHK("fwd lo", 1'b0, fwd)
  endtask
  task t_reset;
    ref_p = 1'b1;
    ref_n = 1'b0;
    half = 8'h08;
    repeat (5) @(negedge ref_clk);
    `CHK("fwd pre", 1'b1, fwd)
    reset_n = 1'b0;
    #1 `CHK("rst fwd", 1'b0, fwd)
    `CHK("rst lock", 1'b0, locked)
    `CHK("rst core", 1'b0, core_rst_n)
    @(negedge ref_clk) reset_n = 1'b1;
  endtask
  // off-rate pll at both rates: lock, config and core release never come
  task t_nolock;
    seen = 1'b0;
    half = 8'h0C;
    for (i = 0; i < 34000; i++)
    begin
      @(negedge ref_clk) rate_20g = (i >= 17000);
      seen = seen | locked | cfg | core_rst_n;
    end
    `CHK("lock seen", 1'b0, seen)
    `CHK("core rst", 1'b0, core_rst_n)
  endtask
  // reset, lock at 10G on a 1.25 MHz tap, hold, then lose it
  task t_lock;
    @(negedge ref_clk);
    rate_20g = 1'b0;
    half = 8'h10;
    reset_n = 1'b0;
    @(negedge ref_clk) reset_n = 1'b1;
    n = 0;
    while (!locked && n < 17000)
    begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("lock 10g", 1'b1, locked)
    `CHK("lock time", 1'b1, n >= 16000 && n <= 16010)
    @(negedge ref_clk);
    `CHK("cfg 10g", 1'b1, cfg)
    `CHK("core rel", 1'b1, core_rst_n)
    repeat (4100) @(negedge ref_clk);
    `CHK("lock holds", 1'b1, locked)
    half = 8'h0C;
    n = 0;
    while (locked && n < 8100)
    begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("lock lost", 1'b0, locked)
    @(negedge ref_clk);
    `CHK("core held", 1'b0, core_rst_n)
    `CHK("cfg lost", 1'b0, cfg)
  endtask
  // relock at 20G on a 2.5 MHz tap
  task t_lock20;
    rate_20g = 1'b1;
    half = 8'h08;
    n = 0;
    while (!locked && n < 21000)
    begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("lock 20g", 1'b1, locked)
    @(negedge ref_clk);
    `CHK("core 20g", 1'b1, core_rst_n)
  endtask
  task results;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    {reset_n, shared, rate_20g, ref_se, ref_p, ref_n} = 6'h01;
    half = 8'h00;
    err_total = 0;
    checks = 0;
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    t_fwd;
    t_reset;
    t_nolock;
    t_lock;
    t_lock20;
    results;
  end
endmodule // transceiver_clock_reset_tb
